// [rtl/eepwc_host.sv]
// Host controller that writes pages into a byte-wide asynchronous EEPROM
// Operation
// R1 - Device holds 8192 bytes, 13-bit address
// R2 - One to thirty-two byte loads per write
// R3 - Device commits page within ten milliseconds
// R4 - Only loaded bytes are changed
// R5 - Write only with output-enable inactive
// R6 - Device blocks writes when supply low
// R7 - Ready/busy low from first write-enable rise
// R8 - Ready/busy high when write completes
// R9 - After completion, deselect the device
// R10 - Next write only after polling shows done; host still takes one after a timeout
// R11 - Window timer restarts at write-enable rise
// R12 - Write-enable fall halts the window timer
// R13 - Polled read shows inverted MSB while busy
// R14 - Page bytes share upper eight address bits
`default_nettype none
module eepwc_host #(
	parameter int WINDOW_CYCLES = eepwc_pkg::WINDOW_CYC,
	parameter int WRITE_CYCLES  = eepwc_pkg::WRITE_CYC
) (
	input  wire logic                        i_ref_clk,
	input  wire logic                        i_arst_n,
	input  wire logic                        i_req_valid,
	input  wire logic [eepwc_pkg::ADDR_W-1:0] i_req_addr,
	input  wire logic [eepwc_pkg::DATA_W-1:0] i_req_data,
	input  wire logic                        i_req_last,
	output logic                             o_req_ready,
	output logic                             o_done,
	output logic                             o_timeout,
	output logic                             o_busy,
	output logic                             o_ce_n,
	output logic                             o_oe_n,
	output logic                             o_we_n,
	output logic [eepwc_pkg::ADDR_W-1:0]     o_addr,
	output logic [eepwc_pkg::DATA_W-1:0]     o_data,
	output logic                             o_data_oe,
	input  wire logic [eepwc_pkg::DATA_W-1:0] i_data,
	input  wire logic                        i_ready_busy
);
	// ==========================================================
	// State
	typedef struct packed {
		eepwc_pkg::eepwc_state_t           st;
		eepwc_pkg::eepwc_pins_t            pin;
		eepwc_pkg::eepwc_req_t             cur;
		logic [eepwc_pkg::ADDR_W-1:0]      last_addr;
		logic [eepwc_pkg::DATA_W-1:0]      last_data;
		logic [eepwc_pkg::ADDR_W-1:0]      page;
		logic [eepwc_pkg::OFS_W:0]         loads;
		logic [eepwc_pkg::CNT_W-1:0]       cnt;
		logic [eepwc_pkg::CNT_W-1:0]       wcnt;
		logic                              ready;
		logic                              done;
		logic                              timeout;
		logic                              busy;
	} eepwc_st_t;

	eepwc_st_t s_r;
	eepwc_st_t s_nxt;
	logic      rb_level;
	logic [eepwc_pkg::DATA_W-1:0] din_r;
	logic [eepwc_pkg::DATA_W-1:0] din_s_r;
	logic [eepwc_pkg::DATA_W-1:0] din_t_r;

	eepwc_sync u_rb_sync (
		.i_ref_clk (i_ref_clk),
		.i_arst_n  (i_arst_n),
		.i_async   (i_ready_busy),
		.o_level   (rb_level)
	);

	// Pin data crosses three stages; compare waits well past access time
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			din_r   <= 8'h00;
			din_s_r <= 8'h00;
			din_t_r <= 8'h00;
		end
		else
		begin
			din_r   <= i_data;
			din_s_r <= din_r;
			din_t_r <= din_s_r;
		end
	end

	function automatic logic same_page(input logic [eepwc_pkg::ADDR_W-1:0] a,
		input logic [eepwc_pkg::ADDR_W-1:0] b);
		same_page = (a[eepwc_pkg::ADDR_W-1:eepwc_pkg::OFS_W] ==
			b[eepwc_pkg::ADDR_W-1:eepwc_pkg::OFS_W]);
	endfunction

	function automatic logic [eepwc_pkg::CNT_W-1:0] cyc(input int n);
		cyc = n[eepwc_pkg::CNT_W-1:0];
	endfunction

	// ==========================================================
	// Next state
	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.done    = 1'b0;
		s_nxt.timeout = 1'b0;
		s_nxt.cnt     = (s_r.cnt != '0) ? s_r.cnt - 1'b1 : s_r.cnt;
		case (s_r.st)
			eepwc_pkg::EEPWC_IDLE:
			begin
				s_nxt.pin.ce_n = 1'b1;
				s_nxt.pin.oe_n = 1'b1;
				s_nxt.pin.we_n = 1'b1;
				s_nxt.pin.doe  = 1'b0;
				s_nxt.busy     = 1'b0;
				if (s_r.ready && i_req_valid)
				begin
					s_nxt.ready      = 1'b0;
					s_nxt.cur.addr   = i_req_addr;
					s_nxt.cur.data   = i_req_data;
					s_nxt.cur.last   = i_req_last;
					s_nxt.page       = i_req_addr;
					s_nxt.loads      = '0;
					s_nxt.busy       = 1'b1;
					s_nxt.st         = eepwc_pkg::EEPWC_SETUP;
					s_nxt.cnt        = cyc(eepwc_pkg::SETUP_CYC);
				end
			end
			eepwc_pkg::EEPWC_SETUP:
			begin
				// Keep output-enable high through every load [R5]
				s_nxt.pin.oe_n = 1'b1;
				s_nxt.pin.ce_n = 1'b0;
				s_nxt.pin.addr = s_r.cur.addr;
				s_nxt.pin.dout = s_r.cur.data;
				s_nxt.pin.doe  = 1'b1;
				if (s_r.cnt == '0)
				begin
					// Falling write-enable halts the device window timer [R12]
					s_nxt.pin.we_n = 1'b0;
					s_nxt.st       = eepwc_pkg::EEPWC_PULSE;
					s_nxt.cnt      = cyc(eepwc_pkg::WP_CYC);
				end
			end
			eepwc_pkg::EEPWC_PULSE:
			begin
				if (s_r.cnt == '0)
				begin
					// Rising edge loads the byte and restarts the window [R11] [R7]
					s_nxt.pin.we_n = 1'b1;
					s_nxt.last_addr = s_r.cur.addr;
					s_nxt.last_data = s_r.cur.data;
					s_nxt.loads    = s_r.loads + 1'b1;
					s_nxt.st       = eepwc_pkg::EEPWC_HIGH;
					s_nxt.cnt      = cyc(eepwc_pkg::WH_CYC);
				end
			end
			eepwc_pkg::EEPWC_HIGH:
			begin
				// Stay inside the page, at most 32 loads [R2] [R14]
				if (!s_r.cur.last && s_r.loads < 6'(eepwc_pkg::PAGE_BYTES))
				begin
					s_nxt.ready = (s_r.cnt == '0);
					if (s_r.ready && i_req_valid && same_page(i_req_addr, s_r.page))
					begin
						s_nxt.ready    = 1'b0;
						s_nxt.cur.addr = i_req_addr;
						s_nxt.cur.data = i_req_data;
						s_nxt.cur.last = i_req_last;
						s_nxt.st       = eepwc_pkg::EEPWC_SETUP;
						s_nxt.cnt      = cyc(eepwc_pkg::SETUP_CYC);
					end
				end
				else if (s_r.cnt == '0)
				begin
					s_nxt.ready   = 1'b0;
					s_nxt.pin.doe = 1'b0;
					s_nxt.pin.ce_n = 1'b1;
					// Let the window lapse before polling [R11] [R3]
					s_nxt.st      = eepwc_pkg::EEPWC_WAIT;
					s_nxt.cnt     = cyc(WINDOW_CYCLES);
					s_nxt.wcnt    = cyc(WRITE_CYCLES);
				end
				// Caller waiting too long keeps ready high and stays in this state
				if (s_r.ready && !i_req_valid && s_r.cnt == '0 && s_nxt.st == s_r.st)
				begin
					s_nxt.ready = 1'b1;
				end
			end
			eepwc_pkg::EEPWC_WAIT:
			begin
				s_nxt.wcnt = (s_r.wcnt != '0) ? s_r.wcnt - 1'b1 : s_r.wcnt;
				if (s_r.cnt == '0)
				begin
					s_nxt.st  = eepwc_pkg::EEPWC_POLL;
				end
			end
			eepwc_pkg::EEPWC_POLL:
			begin
				s_nxt.wcnt = (s_r.wcnt != '0) ? s_r.wcnt - 1'b1 : s_r.wcnt;
				s_nxt.pin.addr = s_r.last_addr;
				s_nxt.pin.we_n = 1'b1;
				s_nxt.pin.ce_n = 1'b0;
				s_nxt.pin.oe_n = 1'b0;
				s_nxt.st       = eepwc_pkg::EEPWC_PREAD;
				s_nxt.cnt      = cyc(eepwc_pkg::READ_CYC);
			end
			eepwc_pkg::EEPWC_PREAD:
			begin
				s_nxt.wcnt = (s_r.wcnt != '0) ? s_r.wcnt - 1'b1 : s_r.wcnt;
				if (s_r.cnt == '0)
				begin
					// True data and ready/busy high means done [R10] [R13] [R8]
					if (rb_level && din_t_r == s_r.last_data)
					begin
						s_nxt.st = eepwc_pkg::EEPWC_DESEL;
					end
					else if (s_r.wcnt == '0)
					begin
						s_nxt.timeout = 1'b1;
						s_nxt.st      = eepwc_pkg::EEPWC_DESEL;
					end
					else
					begin
						s_nxt.pin.oe_n = 1'b1;
						s_nxt.pin.ce_n = 1'b1;
						s_nxt.st       = eepwc_pkg::EEPWC_POLL;
					end
				end
			end
			eepwc_pkg::EEPWC_DESEL:
			begin
				// Chip-enable high ends the cycle cleanly [R9]
				s_nxt.pin.ce_n = 1'b1;
				s_nxt.pin.oe_n = 1'b1;
				s_nxt.done     = ~s_r.timeout;
				s_nxt.busy     = 1'b0;
				s_nxt.ready    = 1'b1;
				s_nxt.st       = eepwc_pkg::EEPWC_IDLE;
			end
			default:
			begin
				s_nxt.st = eepwc_pkg::EEPWC_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			s_r          <= '0;
			s_r.st       <= eepwc_pkg::EEPWC_IDLE;
			s_r.pin.ce_n <= 1'b1;
			s_r.pin.oe_n <= 1'b1;
			s_r.pin.we_n <= 1'b1;
			s_r.ready    <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign o_req_ready = s_r.ready;
	assign o_done      = s_r.done;
	assign o_timeout   = s_r.timeout;
	assign o_busy      = s_r.busy;
	assign o_ce_n      = s_r.pin.ce_n;
	assign o_oe_n      = s_r.pin.oe_n;
	assign o_we_n      = s_r.pin.we_n;
	assign o_addr      = s_r.pin.addr;
	assign o_data      = s_r.pin.dout;
	assign o_data_oe   = s_r.pin.doe;
endmodule
`default_nettype wire

// [rtl/eepwc_pkg.sv]
// Package of constants and types for the EEPROM page write host controller
`default_nettype none
package eepwc_pkg;
	// ==========================================================
	// Geometry
	localparam int ADDR_W      = 13;
	localparam int DATA_W      = 8;
	localparam int OFS_W       = 5;
	localparam int PAGE_BYTES  = 32;
	// ==========================================================
	// Timing
	localparam int CLK_MHZ     = 200;
	localparam int T_WP_NS     = 150;
	localparam int T_WH_NS     = 100;
	localparam int T_SETUP_NS  = 20;
	localparam int T_READ_NS   = 350;
	localparam int T_WINDOW_US = 100;
	localparam int T_WRITE_MS  = 10;
	localparam int WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int WH_CYC      = (T_WH_NS * CLK_MHZ + 999) / 1000;
	localparam int SETUP_CYC   = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
	localparam int READ_CYC    = (T_READ_NS * CLK_MHZ + 999) / 1000;
	localparam int WINDOW_CYC  = T_WINDOW_US * CLK_MHZ;
	localparam int WRITE_CYC   = T_WRITE_MS * 1000 * CLK_MHZ;
	localparam int CNT_W       = 24;
	localparam logic [2:0] SYNC_RST = 3'h7;
	// ==========================================================
	// Types
	typedef enum logic [2:0] {
		EEPWC_IDLE  = 3'h0,
		EEPWC_SETUP = 3'h1,
		EEPWC_PULSE = 3'h3,
		EEPWC_HIGH  = 3'h2,
		EEPWC_WAIT  = 3'h6,
		EEPWC_POLL  = 3'h7,
		EEPWC_PREAD = 3'h5,
		EEPWC_DESEL = 3'h4
	} eepwc_state_t;

	typedef struct packed {
		logic              ce_n;
		logic              oe_n;
		logic              we_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dout;
		logic              doe;
	} eepwc_pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              last;
	} eepwc_req_t;
endpackage
`default_nettype wire

// [rtl/eepwc_sync.sv]
// Three-stage input synchroniser with agreement detect
`default_nettype none
module eepwc_sync (
	input  wire logic i_ref_clk,
	input  wire logic i_arst_n,
	input  wire logic i_async,
	output logic      o_level
);
	logic [2:0] sync_r;
	logic       level_r;

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			sync_r  <= eepwc_pkg::SYNC_RST;
			level_r <= 1'b1;
		end
		else
		begin
			sync_r <= {sync_r[1:0], i_async};
			// Stage 0 feeds only stage 1; decide on stages 1 and 2
			if (sync_r[1] == sync_r[2])
				level_r <= sync_r[2];
		end
	end

	assign o_level = level_r;
endmodule
`default_nettype wire

// [tb/eepwc_host_asserts.sv]
// Pin protocol checker for the page write host controller
`default_nettype none
module eepwc_host_asserts (
	input wire logic        i_ref_clk,
	input wire logic        i_arst_n,
	input wire logic        i_req_valid,
	input wire logic        i_req_last,
	input wire logic        o_req_ready,
	input wire logic        o_done,
	input wire logic        o_timeout,
	input wire logic        o_busy,
	input wire logic        o_ce_n,
	input wire logic        o_oe_n,
	input wire logic        o_we_n,
	input wire logic [12:0] o_addr,
	input wire logic [7:0]  o_data,
	input wire logic        o_data_oe
);
	// ==========================================================
	// Properties
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	property p_wr; !o_we_n |-> o_oe_n && !o_ce_n; endproperty
	a_wr: assert property (p_wr) else $error("write with read strobe");
	property p_rd; !o_oe_n |-> !o_data_oe; endproperty
	a_rd: assert property (p_rd) else $error("data driven in read");
	property p_pw; $fell(o_we_n) |-> ##30 !o_we_n ##1 o_we_n; endproperty
	a_pw: assert property (p_pw) else $error("write pulse width");
	property p_hold; !o_we_n |-> $stable(o_addr) && $stable(o_data) && o_data_oe; endproperty
	a_hold: assert property (p_hold) else $error("bus moved in pulse");
	property p_last; i_req_valid && o_req_ready && i_req_last |=> !o_req_ready; endproperty
	a_last: assert property (p_last) else $error("taken past last");
	property p_busy; i_req_valid && o_req_ready |=> o_busy; endproperty
	a_busy: assert property (p_busy) else $error("busy not set");
	property p_done; o_done |=> !o_done; endproperty
	a_done: assert property (p_done) else $error("done not a pulse");
	property p_desel; o_done |-> o_ce_n && o_we_n; endproperty
	a_desel: assert property (p_desel) else $error("not deselected");
	property p_tmo; o_timeout |-> !o_done ##1 (o_ce_n && o_oe_n && !o_done); endproperty
	a_tmo: assert property (p_tmo) else $error("timeout with done");
	c_done: cover property (o_done);
	c_tmo: cover property (o_timeout);
	c_last: cover property (i_req_valid && o_req_ready && i_req_last);
endmodule
bind eepwc_host eepwc_host_asserts i_eepwc_host_asserts (.i_ref_clk(i_ref_clk),
	.i_arst_n(i_arst_n), .i_req_valid(i_req_valid), .i_req_last(i_req_last),
	.o_req_ready(o_req_ready), .o_done(o_done), .o_timeout(o_timeout), .o_busy(o_busy),
	.o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_data(o_data),
	.o_data_oe(o_data_oe));
`default_nettype wire

// [tb/eepwc_mem_model.sv]
// Behavioural model of the page write memory
`default_nettype none
module eepwc_mem_model #(
	parameter int WIN  = 40,
	parameter int PROG = 300,
	parameter int SLOW = 2500
) (
	input wire logic        i_ref_clk,
	input wire logic        i_arst_n,
	input wire logic        i_ce_n,
	input wire logic        i_oe_n,
	input wire logic        i_we_n,
	input wire logic [12:0] i_addr,
	input wire logic [7:0]  i_data,
	input wire logic        i_supply_low,
	input wire logic        i_slow,
	output logic [7:0]      o_data,
	output logic            o_ready_busy
);
	// ==========================================================
	// Array, page buffer and window timer
	logic [7:0]  mem [8192];
	logic [7:0]  pbuf [32];
	logic [31:0] loaded;
	logic [7:0]  page;
	logic [4:0]  last;
	logic        we_d, armed, inpage, busy;
	int          win, prog;
	initial foreach (mem[k]) mem[k] = 8'hff;
	assign o_ready_busy = !inpage;
	always @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			{we_d, armed, inpage, busy, loaded, o_data} <= {4'h8, 32'h0, 8'h00};
			win <= 0;
			prog <= 0;
		end
		else
		begin
			we_d <= i_we_n;
			// Load on strobe rise only; busy array ignores the bus
			if (!busy && i_we_n && !we_d && !i_ce_n && i_oe_n && !i_supply_low
				&& (!inpage || i_addr[12:5] == page))
			begin
				pbuf[i_addr[4:0]] <= i_data;
				loaded[i_addr[4:0]] <= 1'b1;
				{page, last} <= i_addr;
				{inpage, armed} <= 2'h3;
				win <= 0;
			end
			else if (!i_we_n)
				armed <= 1'b0;
			else if (armed && win == WIN)
				{armed, busy, prog} <= {2'h1, 32'h0};
			else if (armed)
				win <= win + 1;
			if (busy && prog == (i_slow ? SLOW : PROG))
			begin
				for (int k = 0; k < 32; k++)
					if (loaded[k]) mem[{page, k[4:0]}] <= pbuf[k];
				{loaded, busy, inpage} <= '0;
			end
			else if (busy)
				prog <= prog + 1;
			// Released bus toggles so a stale byte never looks valid
			if (!i_ce_n && !i_oe_n && !(busy && i_addr != {page, last}))
				o_data <= busy ? {~pbuf[last][7], pbuf[last][6:0]} : mem[i_addr];
			else
				o_data <= ~o_data;
		end
	end
endmodule
`default_nettype wire

// [tb/test_eepwc_host.sv]
// Self-checking bench for the page write host controller
`default_nettype none
module test_eepwc_host;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0, rst_n = 1'b0, valid = 1'b0, last = 1'b0, slow = 1'b0;
	logic [12:0] a_in = '0, addr;
	logic [7:0]  d_in = '0, wdata, rdata, bus;
	logic        ready, done, tmo, busy, ce_n, oe_n, we_n, doe, rb;
	int          mismatches = 0;
	int          n_compared = 0;
	always #2.5 clk = ~clk;
	assign bus = doe ? wdata : rdata;
	eepwc_host #(.WINDOW_CYCLES(50), .WRITE_CYCLES(2000)) i_eepwc_host (.i_ref_clk(clk),
		.i_arst_n(rst_n), .i_req_valid(valid), .i_req_addr(a_in), .i_req_data(d_in),
		.i_req_last(last), .o_req_ready(ready), .o_done(done), .o_timeout(tmo), .o_busy(busy),
		.o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_addr(addr), .o_data(wdata),
		.o_data_oe(doe), .i_data(bus), .i_ready_busy(rb));
	eepwc_mem_model i_eepwc_mem_model (.i_ref_clk(clk), .i_arst_n(rst_n), .i_ce_n(ce_n),
		.i_oe_n(oe_n), .i_we_n(we_n), .i_addr(addr), .i_data(bus), .i_supply_low(1'b0),
		.i_slow(slow), .o_data(rdata), .o_ready_busy(rb));
	// ==========================================================
	// Shared tasks
	task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic send(input logic [12:0] a, input logic [7:0] d, input logic l);
		int n;
		n = 0;
		{valid, a_in, d_in, last} <= {1'b1, a, d, l};
		do
		begin
			@(posedge clk);
			n++;
		end
		while (ready !== 1'b1 && n < 400);
		check_byte("take", 8'h01, {7'h0, ready});
		valid <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_end(input logic exp_done);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (done !== 1'b1 && tmo !== 1'b1 && n < 4000);
		check_byte("done timeout", {6'h0, exp_done, !exp_done}, {6'h0, done, tmo});
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_single;
		send(13'h0045, 8'ha5, 1'b1);
		wait_end(1'b1);
		check_byte("byte", 8'ha5, i_eepwc_mem_model.mem[13'h0045]);
		check_byte("neighbour", 8'hff, i_eepwc_mem_model.mem[13'h0044]);
		send(13'h0045, 8'h5a, 1'b1);
		wait_end(1'b1);
		check_byte("rewrite", 8'h5a, i_eepwc_mem_model.mem[13'h0045]);
	endtask
	task automatic t_page;
		for (int i = 0; i < 32; i++)
		begin
			send({8'h12, i[4:0]}, 8'(i * 7 + 3), i == 31);
			if (i == 0) check_byte("busy", 8'h01, {7'h0, busy});
		end
		wait_end(1'b1);
		for (int i = 0; i < 32; i++)
			check_byte("page", 8'(i * 7 + 3), i_eepwc_mem_model.mem[{8'h12, i[4:0]}]);
	endtask
	task automatic t_slow;
		int n;
		n = 0;
		slow <= 1'b1;
		send(13'h0100, 8'h3c, 1'b1);
		wait_end(1'b0);
		while (rb !== 1'b1 && n < 2000)
		begin
			@(posedge clk);
			n++;
		end
		check_byte("slow", 8'h3c, i_eepwc_mem_model.mem[13'h0100]);
		slow <= 1'b0;
	endtask
	task automatic finish_test;
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_single;
		t_page;
		t_slow;
		finish_test;
	end
	initial
	begin
		#150000;
		mismatches++;
		finish_test;
	end
endmodule
`default_nettype wire
